// File: hw/mcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_regs
  import mcr_pkg::*;
#(
  parameter logic [63:0] CHIP_IDENT = 64'h0000_00a5_0000_005a, // Arbitrary
  parameter logic [31:0] TEMP_TRIM  = 32'h0000_0000   // Factory trim
) (
  input  wire logic          mclk,            // 200 MHz clock
  input  wire logic          arst_n,          // Async reset, active low
  input  wire logic          ce,              // Clock enable
  input  wire logic          req,             // Transaction strobe
  input  wire logic          req_wr,          // High: write
  input  wire logic [11:0]   req_addr,        // Register address
  input  wire logic [31:0]   req_wdata,       // Write data
  input  wire logic          req_wide,        // High: 32-bit transfer
  input  wire logic          req_uart,        // High: came over UART
  output logic               rsp_valid,       // Answer strobe
  output logic      [31:0]   rsp_rdata,       // Read data
  output logic               meas_run,        // Metering enabled
  output logic [HPF_W-1:0]   hpf_corner,      // Filter corner select
  output logic               user_period_src, // User period source
  input  wire logic          zx_volt_a,       // Volt A pos-neg crossing
  input  wire logic          zx_curr_a,       // Curr A pos-neg crossing
  input  wire logic          zx_curr_b,       // Curr B pos-neg crossing
  input  wire logic          dip_active,      // Dip condition present
  input  wire logic          swell_active,    // Swell condition present
  input  wire logic [31:0]   vrms_a,          // Volt A half-cycle rms
  input  wire logic          period_valid,    // New line period
  input  wire logic [31:0]   period_a,        // Line period value
  input  wire logic [31:0]   noload_in,       // No-load flags
  input  wire logic [15:0]   sign_in          // Power sign flags
);
  localparam int SCAN_MAX = 27;

  logic [31:0]     rw_ff [NRW];
  logic [31:0]     dip_ff, swell_ff, period_ff, noload_ff;
  logic [15:0]     sign_ff;
  logic [31:0]     last_word_ff;
  logic [15:0]     last_half_ff, last_cmd_ff;
  logic [15:0]     read_crc_ff, cfg_crc_ff, scan_crc_ff;
  logic [15:0]     ang_ff [2];
  logic [15:0]     ang_cnt_ff [2];
  logic            ang_busy_ff [2];
  logic [4:0]      scan_idx_ff;
  mcr_scan_t       scan_st_ff;
  logic            rsp_valid_ff, run_ff, ups_ff;
  logic [31:0]     rsp_rdata_ff;
  logic [HPF_W-1:0] hpf_ff;
  logic [31:0]     nxt_rdata, xfer_data, scan_word;
  logic [15:0]     rd_crc, nxt_scan_crc;
  logic            scan_wide;
  logic [1:0]      zx_start, zx_stop;

  assign rsp_valid       = rsp_valid_ff;
  assign rsp_rdata       = rsp_rdata_ff;
  assign meas_run        = run_ff;
  assign hpf_corner      = hpf_ff;
  assign user_period_src = ups_ff;

  // Writable registers; 16-bit ones keep upper bits at zero
  for (genvar g = 0; g < NRW; g++) begin : g_rw
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        rw_ff[g] <= RW_RST[g]; // [RQ18]
      end else if (ce && req && req_wr && req_addr == RW_ADDR[g]) begin
        rw_ff[g] <= RW_WIDE[g] ? req_wdata : (req_wdata & HALF_MASK);
      end
    end
    // Every writable word takes its write, half words masked
    a_rw_land: assert property (@(posedge mclk) disable iff (!arst_n)
      ce && req && req_wr && req_addr == RW_ADDR[g] |=> rw_ff[g] ==
      (RW_WIDE[g] ? $past(req_wdata) : $past(req_wdata) & HALF_MASK))
      else $error("writable register did not take write");
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    nxt_rdata = ZERO32;
    for (int i = 0; i < NRW; i++) begin
      if (req_addr == RW_ADDR[i]) nxt_rdata = rw_ff[i];
    end
    case (req_addr)
      A_DIP:    nxt_rdata = dip_ff;
      A_SWELL:  nxt_rdata = swell_ff;
      A_PERIOD: nxt_rdata = period_ff;
      A_NOLOAD: nxt_rdata = noload_ff;
      A_LWORD:  nxt_rdata = last_word_ff;
      A_TRIM:   nxt_rdata = TEMP_TRIM;            // [RQ16]
      A_IDHI:   nxt_rdata = CHIP_IDENT[63:32];    // [RQ15]
      A_IDLO:   nxt_rdata = CHIP_IDENT[31:0];     // [RQ15]
      A_ANG_VI: nxt_rdata = {ZERO16, ang_ff[0]};
      A_ANG_II: nxt_rdata = {ZERO16, ang_ff[1]};
      A_SIGN:   nxt_rdata = {ZERO16, sign_ff};
      A_CFGCRC: nxt_rdata = {ZERO16, cfg_crc_ff};
      A_RDCRC:  nxt_rdata = {ZERO16, read_crc_ff};
      A_LHALF:  nxt_rdata = {ZERO16, last_half_ff};
      A_LCMD:   nxt_rdata = {ZERO16, last_cmd_ff};
      default:  ;
    endcase
  end

  // Data that crossed the port, either direction
  assign xfer_data = req_wr ? req_wdata : nxt_rdata;

  // Answer one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= ZERO32;
    end else if (ce) begin
      rsp_valid_ff <= req;
      if (req && !req_wr) rsp_rdata_ff <= nxt_rdata;
    end
  end

  // Transaction capture registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_word_ff <= ZERO32;
      last_half_ff <= ZERO16;
      last_cmd_ff  <= ZERO16;
    end else if (ce && req) begin
      if (req_wide) last_word_ff <= xfer_data;            // [RQ2]
      if (!req_wide || req_uart) begin
        last_half_ff <= xfer_data[15:0];                  // [RQ3] [RQ4]
      end
      last_cmd_ff <= {req_addr, !req_wr, 3'b000};         // [RQ5]
    end
  end

  // Checksum of the word shifted out on a read
  mcr_crc16 u_rd_crc (
    .seed (CRC_INIT),
    .data (nxt_rdata),
    .wide (req_wide),
    .crc  (rd_crc)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      read_crc_ff <= ZERO16;
    end else if (ce && req && !req_wr) begin
      read_crc_ff <= rd_crc; // [RQ6]
    end
  end

  // Config checksum scan: one register per cycle, loops forever
  // so the result trails any write by at most two full passes
  assign scan_word = rw_ff[scan_idx_ff];
  assign scan_wide = RW_WIDE[scan_idx_ff];

  mcr_crc16 u_cfg_crc (
    .seed (scan_crc_ff),
    .data (scan_word),
    .wide (scan_wide),
    .crc  (nxt_scan_crc)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scan_st_ff  <= SC_IDLE;
      scan_idx_ff <= 5'd0;
      scan_crc_ff <= CRC_INIT;
      cfg_crc_ff  <= ZERO16;
    end else if (ce) begin
      case (scan_st_ff)
        SC_IDLE: begin
          scan_idx_ff <= 5'd0;
          scan_crc_ff <= CRC_INIT;
          scan_st_ff  <= SC_RUN;
        end
        SC_RUN: begin
          scan_crc_ff <= nxt_scan_crc;
          if (scan_idx_ff == 5'(NRW - 1)) begin
            scan_st_ff <= SC_DONE;
          end else begin
            scan_idx_ff <= scan_idx_ff + 5'd1;
          end
        end
        SC_DONE: begin
          cfg_crc_ff <= scan_crc_ff; // [RQ7]
          scan_st_ff <= SC_IDLE;
        end
        default: scan_st_ff <= SC_IDLE;
      endcase
    end
  end

  // Control outputs decoded from writable registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_ff <= 1'b0;
      hpf_ff <= '0;
      ups_ff <= 1'b0;
    end else if (ce) begin
      run_ff <= rw_ff[RWI_START][RUN_BIT];                  // [RQ1]
      hpf_ff <= rw_ff[RWI_FPC][HPF_LSB +: HPF_W];           // [RQ17]
      ups_ff <= rw_ff[RWI_FPC][UPS_BIT];                    // [RQ17]
    end
  end

  // Angle timers: pair 0 volt A to curr A, pair 1 curr A to curr B
  assign zx_start = {zx_curr_a, zx_volt_a};
  assign zx_stop  = {zx_curr_b, zx_curr_a};

  for (genvar k = 0; k < 2; k++) begin : g_ang
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        ang_busy_ff[k] <= 1'b0;
        ang_cnt_ff[k]  <= ZERO16;
        ang_ff[k]      <= ZERO16;
      end else if (ce) begin
        if (!run_ff) begin
          ang_busy_ff[k] <= 1'b0; // Idle until metering starts [RQ1]
        end else if (ang_busy_ff[k] && zx_stop[k]) begin
          ang_ff[k]      <= ang_cnt_ff[k]; // [RQ11] [RQ12]
          ang_busy_ff[k] <= 1'b0;
        end else if (zx_start[k]) begin
          ang_busy_ff[k] <= 1'b1;
          ang_cnt_ff[k]  <= ZERO16;
        end else if (ang_busy_ff[k] && ang_cnt_ff[k] != ANG_MAX) begin
          ang_cnt_ff[k]  <= ang_cnt_ff[k] + 16'd1; // Saturates
        end
      end
    end
  end

  // Power quality results from the metering datapath
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dip_ff    <= DIP_RST;
      swell_ff  <= ZERO32;
      period_ff <= PER_RST;
      noload_ff <= ZERO32;
      sign_ff   <= ZERO16;
    end else if (ce) begin
      if (dip_active) dip_ff <= vrms_a;      // [RQ13]
      if (swell_active) swell_ff <= vrms_a;  // [RQ14]
      if (period_valid) period_ff <= period_a;
      noload_ff <= noload_in;
      sign_ff   <= sign_in;
    end
  end

  // Checks
  sequence s_xfer_word;
    ce && req && req_wide;
  endsequence

  sequence s_ang_stop(int k);
    ce && run_ff && ang_busy_ff[k] && zx_stop[k];
  endsequence

  sequence s_hold_word;
    last_word_ff == $past(xfer_data);
  endsequence

  sequence s_start_write;
    ce && req && req_wr && req_addr == RW_ADDR[RWI_START];
  endsequence

  sequence s_fpc_write;
    ce && req && req_wr && req_addr == RW_ADDR[RWI_FPC];
  endsequence

  sequence s_read_of(logic [11:0] a);
    ce && req && !req_wr && req_addr == a;
  endsequence

  a_word_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    s_xfer_word |=> last_word_ff == $past(xfer_data)) // [RQ2]
    else $error("last word capture wrong");
  a_half_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req && !req_wide && !req_uart
    |=> last_half_ff == $past(xfer_data[15:0])) // [RQ3]
    else $error("last halfword capture wrong");
  a_uart_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req && req_uart && req_wide
    |=> (last_half_ff == $past(xfer_data[15:0])) and s_hold_word) // [RQ4]
    else $error("uart low half capture wrong");
  a_cmd_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req |=> last_cmd_ff[15:4] == $past(req_addr)
    && last_cmd_ff[CMD_RD] == !$past(req_wr)) // [RQ5]
    else $error("last command capture wrong");
  a_read_crc: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req && !req_wr |=> read_crc_ff == $past(rd_crc)
    && rsp_valid_ff) // [RQ6]
    else $error("read checksum not updated");
  a_cfg_scan: assert property (@(posedge mclk) disable iff (!arst_n || !ce)
    scan_st_ff == SC_IDLE |-> ##[1:SCAN_MAX] scan_st_ff == SC_DONE) // [RQ7]
    else $error("config checksum pass too long");
  a_angle_vi: assert property (@(posedge mclk) disable iff (!arst_n)
    s_ang_stop(0) |=> ang_ff[0] == $past(ang_cnt_ff[0])) // [RQ11]
    else $error("volt current angle not latched");
  a_angle_ii: assert property (@(posedge mclk) disable iff (!arst_n)
    s_ang_stop(1) |=> ang_ff[1] == $past(ang_cnt_ff[1])) // [RQ12]
    else $error("current current angle not latched");
  a_dip_store: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && dip_active |=> dip_ff == $past(vrms_a)) // [RQ13]
    else $error("dip value not stored");
  a_swell_store: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && swell_active |=> swell_ff == $past(vrms_a)) // [RQ14]
    else $error("swell value not stored");
  a_ro_write: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req && req_wr && req_addr == A_DIP && !dip_active
    |=> $stable(dip_ff)) // [RQ18]
    else $error("read-only register changed by write");
  a_filter_sel: assert property (@(posedge mclk) disable iff (!arst_n)
    ce |=> hpf_ff == $past(rw_ff[RWI_FPC][HPF_LSB +: HPF_W])) // [RQ17]
    else $error("filter corner does not follow config");
  a_answer_strobe: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && req |=> rsp_valid_ff)
    else $error("answer strobe missing");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !(req && !req_wr) |=> $stable(rsp_rdata_ff))
    else $error("read data changed without a read");
  a_start_write: assert property (@(posedge mclk) disable iff (!arst_n)
    s_start_write ##1 ce |=> run_ff == $past(req_wdata[RUN_BIT], 2)) // [RQ1]
    else $error("run output does not follow start write");
  a_corner_write: assert property (@(posedge mclk) disable iff (!arst_n)
    s_fpc_write ##1 ce
    |=> hpf_ff == $past(req_wdata[HPF_LSB +: HPF_W], 2)
    && ups_ff == $past(req_wdata[UPS_BIT], 2)) // [RQ17]
    else $error("filter outputs do not follow config write");
  a_idle_abort: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !run_ff |=> !ang_busy_ff[0] && !ang_busy_ff[1]) // [RQ1]
    else $error("angle timer busy while idle");
  a_trim_read: assert property (@(posedge mclk) disable iff (!arst_n)
    s_read_of(A_TRIM) |=> rsp_rdata_ff == TEMP_TRIM) // [RQ16]
    else $error("trim word read wrong");
  a_ident_hi: assert property (@(posedge mclk) disable iff (!arst_n)
    s_read_of(A_IDHI) |=> rsp_rdata_ff == CHIP_IDENT[63:32]) // [RQ15]
    else $error("upper ident word read wrong");
  a_ident_lo: assert property (@(posedge mclk) disable iff (!arst_n)
    s_read_of(A_IDLO) |=> rsp_rdata_ff == CHIP_IDENT[31:0]) // [RQ15]
    else $error("lower ident word read wrong");
  a_dip_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !dip_active |=> $stable(dip_ff)) // [RQ13]
    else $error("dip value moved without dip");
  a_swell_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !swell_active |=> $stable(swell_ff)) // [RQ14]
    else $error("swell value moved without swell");
  a_cfg_publish: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && scan_st_ff == SC_DONE |=> cfg_crc_ff == $past(scan_crc_ff)) // [RQ7]
    else $error("config checksum not published");
  a_scan_range: assert property (@(posedge mclk) disable iff (!arst_n)
    scan_idx_ff <= 5'(NRW - 1)) // [RQ7]
    else $error("config scan index out of range");
endmodule // mcr_regs
`default_nettype wire

// File: hw/mcr_pkg.sv
// Overview of operation
// RQ1: Host writes one to start metering
// RQ2: Capture data of every 32-bit transaction
// RQ3: Capture data of every 16-bit transaction
// RQ4: UART transfers capture low sixteen data bits
// RQ5: Capture address and direction of last command
// RQ6: Checksum of data shifted out on read
// RQ7: Keep checksum over all configuration registers
// RQ8: Host keeps phase mode at E4 normally
// RQ9: Host sets computation config to 0005
// RQ10: Host leaves pulse rate limits at reset
// RQ11: Time voltage to current zero crossings
// RQ12: Time current A to current B crossings
// RQ13: Store voltage value while dip present
// RQ14: Store voltage value while swell present
// RQ15: Chip ident upper word first, lower next
// RQ16: Temperature trim read-only, host cannot alter
// RQ17: Filter period config selects corner, source
// RQ18: Read-only stays; writables reset to defaults
`default_nettype none
package mcr_pkg;
  localparam int          NRW       = 25;
  localparam int          AW        = 12;
  // Writable register offsets, in table order
  localparam logic [11:0] RW_ADDR [NRW] = '{
    12'h40f, 12'h410, 12'h414, 12'h41c, 12'h41d, 12'h41e, 12'h420,
    12'h421, 12'h422, 12'h424, 12'h425, 12'h480, 12'h481, 12'h48b,
    12'h48c, 12'h490, 12'h491, 12'h492, 12'h493, 12'h494, 12'h495,
    12'h498, 12'h499, 12'h49a, 12'h4af};
  localparam logic [31:0] RW_RST [NRW] = '{
    32'h0045_d450, 32'h0000_0000, 32'h000f_ffff, 32'h0000_8225,
    32'h0000_8225, 32'h0000_8225, 32'h0010_0000, 32'h0010_0000,
    32'h0010_0000, 32'h0000_00e4, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0300, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_0009, 32'h0000_0000,
    32'h0000_0000};
  // One bit per writable register: set when 32 bits wide
  localparam logic [24:0] RW_WIDE   = 25'h000_07ff;
  localparam logic [31:0] HALF_MASK = 32'h0000_ffff;
  localparam int          RWI_START = 11;
  localparam int          RWI_FPC   = 24;
  // Read-only offsets
  localparam logic [11:0] A_DIP     = 12'h411;
  localparam logic [11:0] A_SWELL   = 12'h415;
  localparam logic [11:0] A_PERIOD  = 12'h418;
  localparam logic [11:0] A_NOLOAD  = 12'h41f;
  localparam logic [11:0] A_LWORD   = 12'h423;
  localparam logic [11:0] A_TRIM    = 12'h471;
  localparam logic [11:0] A_IDHI    = 12'h472;
  localparam logic [11:0] A_IDLO    = 12'h473;
  localparam logic [11:0] A_ANG_VI  = 12'h485;
  localparam logic [11:0] A_ANG_II  = 12'h488;
  localparam logic [11:0] A_SIGN    = 12'h49d;
  localparam logic [11:0] A_CFGCRC  = 12'h4a8;
  localparam logic [11:0] A_RDCRC   = 12'h4a9;
  localparam logic [11:0] A_LHALF   = 12'h4ac;
  localparam logic [11:0] A_LCMD    = 12'h4ae;
  // Reset values of read-only results
  localparam logic [31:0] DIP_RST   = 32'h007f_ffff;
  localparam logic [31:0] PER_RST   = 32'h0050_0000;
  localparam logic [31:0] ZERO32    = 32'h0000_0000;
  localparam logic [15:0] ZERO16    = 16'h0000;
  // Field positions
  localparam int          RUN_BIT   = 0;
  localparam int          HPF_LSB   = 0;
  localparam int          HPF_W     = 3;
  localparam int          UPS_BIT   = 3;
  localparam int          CMD_RD    = 3;
  // Checksum constants and angle timer limit
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] ANG_MAX   = 16'hffff;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_RUN  = 2'b01,
    SC_DONE = 2'b10
  } mcr_scan_t;
endpackage
`default_nettype wire

// File: hw/mcr_crc16.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_crc16
  import mcr_pkg::*;
(
  input  wire logic [15:0] seed,   // Running checksum in
  input  wire logic [31:0] data,   // Word to fold in
  input  wire logic        wide,   // High: 32 bits, low: 16 bits
  output logic      [15:0] crc     // Running checksum out
);
  logic [15:0] c;
  logic        fb;

  // Bitwise fold, most significant bit first as shifted on the wire
  always_comb begin
    c  = seed;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (wide || i < 16) begin
        fb = c[15] ^ data[i];
        c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : ZERO16);
      end
    end
    crc = c;
  end
endmodule // mcr_crc16
`default_nettype wire

// File: test/mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
  input  wire logic        mclk,      // Device clock
  output logic             req,       // Strobe
  output logic             req_wr,    // High: write
  output logic      [11:0] req_addr,  // Offset
  output logic      [31:0] req_wdata, // Write data
  output logic             req_wide,  // 32-bit
  output logic             req_uart,  // Over UART
  input  wire logic        rsp_valid, // Answer
  input  wire logic [31:0] rsp_rdata  // Read data
);
  // Bus idle from time zero
  initial begin
    req       = 1'b0;
    req_wr    = 1'b0;
    req_addr  = 12'h000;
    req_wdata = 32'h0000_0000;
    req_wide  = 1'b0;
    req_uart  = 1'b0;
  end

  // One strobe cycle, answer taken one edge later
  task automatic xfer(input  logic        wr,
                      input  logic [11:0] a,
                      input  logic [31:0] d,
                      input  logic        w,
                      input  logic        u,
                      output logic [31:0] q,
                      output logic        ok);
    @(posedge mclk);
    req       <= 1'b1;
    req_wr    <= wr;
    req_addr  <= a;
    req_wdata <= d;
    req_wide  <= w;
    req_uart  <= u;
    @(posedge mclk);
    // Released address and data lines carry junk, so stale values never pass
    req       <= 1'b0;
    req_addr  <= ~a;
    req_wdata <= ~d;
    #1;
    q  = rsp_rdata;
    ok = rsp_valid;
  endtask
endmodule // mcr_host_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mcr_pkg::*;
();
  localparam logic [63:0] ID_VAL = 64'h0000_0c3c_0000_0e1e; // Arbitrary
  localparam logic [31:0] TR_VAL = 32'h0000_1357; // Arbitrary
  localparam logic [31:0] NL_VAL = 32'h0000_0005;
  localparam logic [15:0] SG_VAL = 16'h0003;
  logic             mclk, arst_n, ce, req, req_wr, req_wide, req_uart;
  logic             rsp_valid, meas_run, user_period_src, last_ok;
  logic             dip_active, swell_active, period_valid;
  logic [11:0]      req_addr;
  logic [31:0]      req_wdata, rsp_rdata, vrms_a, period_a;
  logic [HPF_W-1:0] hpf_corner;
  logic [2:0]       zx;
  logic [31:0]      shadow [NRW];
  int               err_count;
  int               samples_checked;

  mcr_regs #(.CHIP_IDENT(ID_VAL), .TEMP_TRIM(TR_VAL)) i_mcr_regs (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req), .req_wr(req_wr),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_wide(req_wide),
    .req_uart(req_uart), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .meas_run(meas_run), .hpf_corner(hpf_corner),
    .user_period_src(user_period_src), .zx_volt_a(zx[0]),
    .zx_curr_a(zx[1]), .zx_curr_b(zx[2]), .dip_active(dip_active),
    .swell_active(swell_active), .vrms_a(vrms_a),
    .period_valid(period_valid), .period_a(period_a),
    .noload_in(NL_VAL), .sign_in(SG_VAL));

  mcr_host_model i_mcr_host_model (
    .mclk(mclk), .req(req), .req_wr(req_wr), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_wide(req_wide), .req_uart(req_uart),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count = err_count + 1;
    end
  endtask

  task automatic rdq(input logic [11:0] a, input logic w,
                     output logic [31:0] q);
    i_mcr_host_model.xfer(1'b0, a, 32'h0000_0000, w, 1'b0, q, last_ok);
    chk("answer strobe", 32'h0000_0001, {31'h0, last_ok});
  endtask

  task automatic rdc(input logic [11:0] a, input logic w,
                     input logic [31:0] e, input string n);
    logic [31:0] q;
    rdq(a, w, q);
    chk(n, e, q);
  endtask

  // Writes keep a shadow of the writable bank for later compares
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic u = 1'b0);
    logic [31:0] q;
    logic        w;
    w = 1'b1;
    for (int k = 0; k < NRW; k++) begin
      if (RW_ADDR[k] === a) begin
        w = RW_WIDE[k] | u;
        shadow[k] = RW_WIDE[k] ? d : d & HALF_MASK;
      end
    end
    i_mcr_host_model.xfer(1'b1, a, w ? d : d & HALF_MASK, w, u, q,
                          last_ok);
  endtask

  task automatic pulse(input logic [2:0] m, input int gap);
    @(posedge mclk);
    zx <= m;
    @(posedge mclk);
    zx <= 3'b000;
    repeat (gap - 1) @(posedge mclk);
  endtask

  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  task automatic results();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    err_count = err_count + 1;
    results();
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [15:0] c;
    logic [11:0] ro_a [6];
    logic [31:0] ro_v [6];
    ro_a = '{A_TRIM, A_IDHI, A_IDLO, A_PERIOD, A_NOLOAD, A_SIGN};
    ro_v = '{TR_VAL, ID_VAL[63:32], ID_VAL[31:0], PER_RST, NL_VAL,
             {16'h0, SG_VAL}};
    {mclk, arst_n, ce, zx, dip_active, swell_active} = 8'h20;
    {vrms_a, period_a, period_valid} = 65'h0;
    err_count = 0;
    samples_checked = 0;
    foreach (shadow[k]) shadow[k] = RW_RST[k];
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int k = 0; k < NRW; k++) begin
      rdc(RW_ADDR[k], RW_WIDE[k], RW_RST[k], "reset value");
    end
    wr(A_DIP, 32'h0000_1111);
    rdc(A_DIP, 1'b1, DIP_RST, "dip reset");
    for (int k = 0; k < 6; k++) begin
      wr(ro_a[k], 32'hffff_ffff);
      rdc(ro_a[k], 1'b1, ro_v[k], "read-only");
    end
    wr(12'h4b0, 32'h0000_5555);
    rdc(12'h4b0, 1'b1, ZERO32, "unmapped");
    // Bring-up; pulse rate limits are left at reset
    wr(12'h491, 32'h0000_0005);
    wr(12'h424, 32'h0000_00e5);
    wr(12'h424, 32'h0000_00e4);
    wr(12'h480, 32'h0000_0001);
    @(posedge mclk);
    #1;
    chk("run", 32'h1, {31'h0, meas_run});
    wr(12'h4af, 32'h0000_000d);
    @(posedge mclk);
    #1;
    chk("filter", 32'hd, {28'h0, user_period_src, hpf_corner});
    // Capture registers, writes then reads
    wr(12'h481, 32'h0000_abcd);
    rdc(A_LHALF, 1'b0, 32'h0000_abcd, "half");
    rdc(A_LCMD, 1'b0, 32'h0000_4ac8, "cmd");
    rdc(A_LHALF, 1'b0, 32'h0000_4ac8, "half");
    wr(12'h40f, 32'h1234_5678);
    rdc(A_LCMD, 1'b0, 32'h0000_40f0, "cmd");
    rdc(A_LWORD, 1'b1, 32'h1234_5678, "word");
    wr(12'h410, 32'hdead_beef, 1'b1);
    rdc(A_LHALF, 1'b0, 32'h0000_beef, "uart half");
    rdc(12'h40f, 1'b1, 32'h1234_5678, "rw");
    c = crc(CRC_INIT, 32'h1234_5678, 32);
    rdc(A_RDCRC, 1'b0, {16'h0, c}, "read crc");
    c = crc(CRC_INIT, {16'h0, c}, 16);
    rdc(A_RDCRC, 1'b0, {16'h0, c}, "crc16");
    // Frozen clock enable: request not taken
    @(posedge mclk);
    ce <= 1'b0;
    i_mcr_host_model.xfer(1'b1, 12'h48b, 32'h1234, 1'b0, 1'b0, q, last_ok);
    chk("frozen strobe", 32'h0, {31'h0, last_ok});
    @(posedge mclk);
    ce <= 1'b1;
    // Dip then swell, then values move on
    @(posedge mclk);
    vrms_a <= 32'h0012_3456;
    dip_active <= 1'b1;
    period_a <= 32'h0051_0000;
    period_valid <= 1'b1;
    repeat (3) @(posedge mclk);
    {dip_active, swell_active, period_valid} <= 3'b010;
    vrms_a <= 32'h00ab_cdef;
    repeat (3) @(posedge mclk);
    swell_active <= 1'b0;
    vrms_a <= 32'h0000_0777;
    rdc(A_DIP, 1'b1, 32'h0012_3456, "dip");
    rdc(A_SWELL, 1'b1, 32'h00ab_cdef, "swell");
    rdc(A_PERIOD, 1'b1, 32'h0051_0000, "period");
    pulse(3'b001, 20);
    pulse(3'b010, 30);
    pulse(3'b100, 4);
    rdc(A_ANG_VI, 1'b0, 32'd20, "angle");
    rdc(A_ANG_II, 1'b0, 32'd30, "angle");
    repeat (60) @(posedge mclk);
    c = CRC_INIT;
    for (int k = 0; k < NRW; k++) begin
      c = crc(c, shadow[k], RW_WIDE[k] ? 32 : 16);
      rdc(RW_ADDR[k], RW_WIDE[k], shadow[k], "register");
    end
    rdc(A_CFGCRC, 1'b0, {16'h0, c}, "config crc");
    results();
  end
endmodule // testbench
`default_nettype wire
